// ==== ssdb_pkg.sv ====
// Constants, register layout and types of the serial status and data block.
// Assumes one clock domain and an Avalon-MM slave with word-aligned registers.
package ssdb_pkg;

  // ---------------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  IDX_CONTROL = 8'h28;
  localparam logic [7:0]  IDX_STATUS  = 8'h29;
  localparam logic [7:0]  IDX_DATA    = 8'h2A;
  localparam logic [7:0]  IDX_OPTIONS = 8'h38;
  localparam logic [7:0]  IDX_EVENT   = 8'h3C;
  localparam logic [7:0]  IDX_MASK    = 8'h3D;

  function automatic logic [7:0] ssdb_byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : ssdb_byte_addr

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ST_DONE     = 7;
  localparam int ST_WRITE_COLLISION_FLAG     = 6;
  localparam int ST_MODE_FAULT_FLAG     = 4;
  localparam int CT_IRQ_EN   = 7;
  localparam int CT_ENABLE   = 6;
  localparam int CT_WIRED_OR = 5;
  localparam int CT_MASTER   = 4;
  localparam int CT_CPOL     = 3;
  localparam int CT_CPHA     = 2;
  localparam int CT_RATE_HI  = 1;
  localparam int CT_RATE_LO  = 0;
  localparam int OP_BIT_ORDER  = 3;
  localparam int OP_EXTRA_RATE = 2;
  localparam int EV_DONE     = 0;
  localparam int EV_WRITE_COLLISION_FLAG     = 1;
  localparam int EV_MODE_FAULT_FLAG     = 2;
  localparam int EV_W        = 3;

  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] OPTIONS_RESET = 8'h00;
  localparam logic [7:0] OPTIONS_MASK  = 8'hFC;
  localparam logic [7:0] BYTE_RESET    = 8'h00;

  // ---------------------------------------------------------------------------
  // Transfer shape and clock divider
  // ---------------------------------------------------------------------------
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam int BASE_DIV [4] = '{2, 4, 16, 32};
  localparam int PRESCALE     = 4;

  typedef enum logic [1:0] {
    SSDB_IDLE = 2'b01,
    SSDB_RUN  = 2'b10
  } ssdb_xfer_t;

  // Half the E clock divide ratio, less one, for a rate select code.
  function automatic logic [5:0] ssdb_half_m1(input logic [2:0] sel);
    int d;
    d = BASE_DIV[sel[1:0]];
    if (sel[2]) begin
      d = d * PRESCALE;
    end
    return 6'(d / 2 - 1);
  endfunction : ssdb_half_m1

endpackage : ssdb_pkg

// ==== ssdb_clkdiv.sv ====
// Serial clock divider: one tick per half period of the master serial clock.
// Assumes rate select stays steady while run is high.
`timescale 1ns/10ps
module ssdb_clkdiv (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] rate_sel,
  output logic            tick
);

  logic [5:0] count_reg;
  logic [5:0] count_next;
  logic [5:0] limit;

  assign limit      = ssdb_pkg::ssdb_half_m1(rate_sel);
  assign tick       = run & (count_reg == limit);
  assign count_next = (~run | tick) ? 6'h00 : count_reg + 6'h01;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule : ssdb_clkdiv

// ==== ssdb_shifter.sv ====
// Byte shift engine for master and slave transfers with phase and bit order.
// Assumes synchronised serial inputs and one tick per master half period.
`timescale 1ns/10ps
module ssdb_shifter (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       load,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [7:0] load_data,
  input  wire logic       master,
  input  wire logic       cpha,
  input  wire logic       bit_order_select,
  input  wire logic       tick,
  input  wire logic       sck_sync,
  input  wire logic       select_sync,
  input  wire logic       in_bit,
  output logic            sck_level,
  output logic            out_bit,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_data
);

  ssdb_pkg::ssdb_xfer_t state_reg;
  ssdb_pkg::ssdb_xfer_t state_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [3:0] edge_reg;
  logic [3:0] edge_next;
  logic       sck_reg;
  logic       sck_prev_reg;
  logic       out_reg;
  logic       out_next;
  logic       done_reg;

  function automatic logic first_bit(input logic [7:0] d, input logic lsb_first);
    return lsb_first ? d[0] : d[7];
  endfunction : first_bit

  wire       running     = (state_reg == ssdb_pkg::SSDB_RUN);
  wire       master_edge = master & running & tick;
  wire       slave_edge  = ~master & running & select_sync & (sck_sync ^ sck_prev_reg);
  wire       any_edge    = master_edge | slave_edge;
  wire       leading     = ~edge_reg[0];
  wire       sample      = any_edge & (leading ^ cpha);
  wire       drive       = any_edge & ~(leading ^ cpha);
  wire       last        = any_edge & (edge_reg == ssdb_pkg::LAST_EDGE);
  // Bit order only changes the shift direction, never the byte layout.
  wire [7:0] shifted     = bit_order_select ? {in_bit, shift_reg[7:1]}
                                : {shift_reg[6:0], in_bit};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssdb_pkg::SSDB_IDLE: begin
        if (start | (~master & select_sync)) begin
          state_next = ssdb_pkg::SSDB_RUN;
        end
      end
      ssdb_pkg::SSDB_RUN: begin
        if (abort | (master & last) | (~master & ~select_sync)) begin
          state_next = ssdb_pkg::SSDB_IDLE;
        end
      end
      default: state_next = ssdb_pkg::SSDB_IDLE;
    endcase
  end

  assign edge_next  = ~running ? 4'h0 : (any_edge ? edge_reg + 4'h1 : edge_reg);
  assign shift_next = load ? load_data : (sample ? shifted : shift_reg);
  assign out_next   = load ? first_bit(load_data, bit_order_select) :
                      (drive | ~running) ? first_bit(shift_reg, bit_order_select) : out_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= ssdb_pkg::SSDB_IDLE;
      shift_reg    <= ssdb_pkg::BYTE_RESET;
      edge_reg     <= 4'h0;
      sck_reg      <= 1'b0;
      sck_prev_reg <= 1'b0;
      out_reg      <= 1'b0;
      done_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      shift_reg    <= shift_next;
      edge_reg     <= edge_next;
      sck_reg      <= running & (sck_reg ^ master_edge);
      sck_prev_reg <= sck_sync;
      out_reg      <= out_next;
      done_reg     <= last & ~abort;
    end
  end

  assign sck_level = sck_reg;
  assign out_bit   = out_reg;
  assign busy      = running;
  assign done      = done_reg;
  assign rx_data   = shift_reg;

endmodule : ssdb_shifter

// ==== ssdb_top.sv ====
// Serial port status flags, data buffer and option bits behind an Avalon-MM slave.
// Assumes one 40 MHz clock; serial pins are asynchronous and are synchronised here.
//
// Overview of operation
// - Set transfer done flag, status bit seven
// - Interrupt when done flag set and enabled
// - Clear done: status read, then data access
// - Ignore data writes until flagged status read
// - Collision flag bit six, same clearing sequence
// - Only master data writes start a transfer
// - Done flag set in master and slave
// - Data reads return the receive buffer
// - Bit order option shifts LSB first
// - Extra rate option adds divide by four
// - Master clock divides E by 2 to 128
`timescale 1ns/10ps
module ssdb_top (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [ssdb_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             irq,
  input  wire logic                        sck_in,
  output logic                             sck_out,
  output logic                             sck_oe,
  input  wire logic                        mosi_in,
  output logic                             mosi_out,
  output logic                             mosi_oe,
  input  wire logic                        miso_in,
  output logic                             miso_out,
  output logic                             miso_oe,
  input  wire logic                        select_n_in
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end else begin
      sync1_reg <= {select_n_in, miso_in, mosi_in, sck_in};
      sync2_reg <= sync1_reg;
    end
  end

  wire sck_s         = sync2_reg[0];
  wire mosi_s        = sync2_reg[1];
  wire miso_s        = sync2_reg[2];
  wire select_active = ~sync2_reg[3];

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [7:0]            control_reg;
  logic [7:0]            control_next;
  logic [7:0]            options_reg;
  logic [7:0]            options_next;
  logic [7:0]            rx_buffer_reg;
  logic [7:0]            rx_buffer_next;
  logic                  done_flag_reg;
  logic                  done_flag_next;
  logic                  done_armed_reg;
  logic                  done_armed_next;
  logic                  write_collision_flag_flag_reg;
  logic                  write_collision_flag_flag_next;
  logic                  write_collision_flag_armed_reg;
  logic                  write_collision_flag_armed_next;
  logic                  mode_fault_flag_flag_reg;
  logic                  mode_fault_flag_flag_next;
  logic                  mode_fault_flag_armed_reg;
  logic                  mode_fault_flag_armed_next;
  logic [ssdb_pkg::EV_W-1:0] event_reg;
  logic [ssdb_pkg::EV_W-1:0] event_next;
  logic [ssdb_pkg::EV_W-1:0] mask_reg;
  logic [ssdb_pkg::EV_W-1:0] mask_next;
  logic                  ack_reg;
  logic [7:0]            readdata_reg;
  logic [7:0]            read_value;
  logic [7:0]            status_value;
  logic                  irq_reg;
  logic                  irq_next;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // Every access is answered on the second cycle; waitrequest stays high
  // in the first so the read value is settled before it is sampled.
  wire request    = avs_read | avs_write;
  wire accept     = request & ack_reg;
  wire hit_ctrl   = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_CONTROL));
  wire hit_status = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_STATUS));
  wire hit_data   = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_DATA));
  wire hit_opt    = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_OPTIONS));
  wire hit_event  = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_EVENT));
  wire hit_mask   = (avs_address == ssdb_pkg::ssdb_byte_addr(ssdb_pkg::IDX_MASK));
  wire wr_en      = accept & avs_write & avs_byteenable[0];
  wire wr_ctrl    = wr_en & hit_ctrl;
  wire wr_data    = wr_en & hit_data;
  wire wr_opt     = wr_en & hit_opt;
  wire wr_event   = wr_en & hit_event;
  wire wr_mask    = wr_en & hit_mask;
  wire rd_status  = accept & avs_read & hit_status;
  wire data_acc   = accept & hit_data;

  always_comb begin
    status_value                    = 8'h00;
    status_value[ssdb_pkg::ST_DONE] = done_flag_reg;
    status_value[ssdb_pkg::ST_WRITE_COLLISION_FLAG] = write_collision_flag_flag_reg;
    status_value[ssdb_pkg::ST_MODE_FAULT_FLAG] = mode_fault_flag_flag_reg;
  end

  assign read_value = hit_ctrl   ? control_reg :
                      hit_status ? status_value :
                      hit_data   ? rx_buffer_reg :
                      hit_opt    ? options_reg :
                      hit_event  ? {5'h00, event_reg} :
                      hit_mask   ? {5'h00, mask_reg} : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack_reg      <= 1'b0;
      readdata_reg <= 8'h00;
    end else begin
      ack_reg      <= request & ~ack_reg;
      readdata_reg <= (avs_read & ~ack_reg) ? read_value : readdata_reg;
    end
  end

  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata    = {24'h000000, readdata_reg};

  // ---------------------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------------------
  wire       enable   = control_reg[ssdb_pkg::CT_ENABLE];
  wire       master   = control_reg[ssdb_pkg::CT_MASTER];
  wire       wired_or = control_reg[ssdb_pkg::CT_WIRED_OR];
  wire [2:0] rate_sel = {options_reg[ssdb_pkg::OP_EXTRA_RATE],
                         control_reg[ssdb_pkg::CT_RATE_HI],
                         control_reg[ssdb_pkg::CT_RATE_LO]};
  wire       xfer_busy;
  wire       xfer_done;
  wire       tick;
  wire       sck_level;
  wire       out_bit;
  wire [7:0] rx_data;

  wire mode_fault_flag_event   = enable & master & select_active;
  wire write_ok     = wr_data & (~done_flag_reg | done_armed_reg);
  wire write_collision_flag_event   = write_ok & xfer_busy;
  wire load         = write_ok & ~xfer_busy;
  wire start        = load & master & enable;
  wire abort        = mode_fault_flag_event | ~enable;

  ssdb_clkdiv u_clkdiv (
    .clock    (clock),
    .resetn   (resetn),
    .run      (xfer_busy & master),
    .rate_sel (rate_sel),
    .tick     (tick)
  );

  ssdb_shifter u_shifter (
    .clock       (clock),
    .resetn      (resetn),
    .load        (load),
    .start       (start),
    .abort       (abort),
    .load_data   (avs_writedata[7:0]),
    .master      (master),
    .cpha        (control_reg[ssdb_pkg::CT_CPHA]),
    .bit_order_select        (options_reg[ssdb_pkg::OP_BIT_ORDER]),
    .tick        (tick),
    .sck_sync    (sck_s),
    .select_sync (enable & select_active),
    .in_bit      (master ? miso_s : mosi_s),
    .sck_level   (sck_level),
    .out_bit     (out_bit),
    .busy        (xfer_busy),
    .done        (xfer_done),
    .rx_data     (rx_data)
  );

  // ---------------------------------------------------------------------------
  // Status flags and their clearing sequences
  // ---------------------------------------------------------------------------
  // A completion in the same cycle as a clear keeps the flag set.
  wire done_clr = done_armed_reg & data_acc;
  wire write_collision_flag_clr = write_collision_flag_armed_reg & data_acc;
  wire mode_fault_flag_clr = mode_fault_flag_armed_reg & wr_ctrl;

  assign done_flag_next  = xfer_done | (done_flag_reg & ~done_clr);
  assign done_armed_next = done_flag_next & ~done_clr &
                           (done_armed_reg | (rd_status & readdata_reg[ssdb_pkg::ST_DONE]));
  assign write_collision_flag_flag_next  = write_collision_flag_event | (write_collision_flag_flag_reg & ~write_collision_flag_clr);
  assign write_collision_flag_armed_next = write_collision_flag_flag_next & ~write_collision_flag_clr &
                           (write_collision_flag_armed_reg | (rd_status & readdata_reg[ssdb_pkg::ST_WRITE_COLLISION_FLAG]));
  assign mode_fault_flag_flag_next  = mode_fault_flag_event | (mode_fault_flag_flag_reg & ~mode_fault_flag_clr);
  assign mode_fault_flag_armed_next = mode_fault_flag_flag_next & ~mode_fault_flag_clr &
                           (mode_fault_flag_armed_reg | (rd_status & readdata_reg[ssdb_pkg::ST_MODE_FAULT_FLAG]));

  // A byte finished while the previous one is still unread is dropped.
  assign rx_buffer_next = (xfer_done & (~done_flag_reg | done_clr)) ? rx_data
                                                                    : rx_buffer_reg;

  // ---------------------------------------------------------------------------
  // Control, options, event and mask registers
  // ---------------------------------------------------------------------------
  always_comb begin
    control_next = wr_ctrl ? avs_writedata[7:0] : control_reg;
    if (mode_fault_flag_event) begin
      control_next[ssdb_pkg::CT_ENABLE] = 1'b0;
      control_next[ssdb_pkg::CT_MASTER] = 1'b0;
    end
  end

  assign options_next = wr_opt ? (avs_writedata[7:0] & ssdb_pkg::OPTIONS_MASK)
                               : options_reg;
  assign mask_next    = wr_mask ? avs_writedata[ssdb_pkg::EV_W-1:0] : mask_reg;
  assign event_next   = (event_reg & ~(wr_event ? avs_writedata[ssdb_pkg::EV_W-1:0]
                                                : {ssdb_pkg::EV_W{1'b0}}))
                        | {mode_fault_flag_event, write_collision_flag_event, xfer_done};

  assign irq_next = (control_reg[ssdb_pkg::CT_IRQ_EN] & (done_flag_reg | mode_fault_flag_flag_reg))
                    | (|(event_reg & mask_reg));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control_reg    <= ssdb_pkg::CONTROL_RESET;
      options_reg    <= ssdb_pkg::OPTIONS_RESET;
      rx_buffer_reg  <= ssdb_pkg::BYTE_RESET;
      done_flag_reg  <= 1'b0;
      done_armed_reg <= 1'b0;
      write_collision_flag_flag_reg  <= 1'b0;
      write_collision_flag_armed_reg <= 1'b0;
      mode_fault_flag_flag_reg  <= 1'b0;
      mode_fault_flag_armed_reg <= 1'b0;
      event_reg      <= {ssdb_pkg::EV_W{1'b0}};
      mask_reg       <= {ssdb_pkg::EV_W{1'b0}};
      irq_reg        <= 1'b0;
    end else begin
      control_reg    <= control_next;
      options_reg    <= options_next;
      rx_buffer_reg  <= rx_buffer_next;
      done_flag_reg  <= done_flag_next;
      done_armed_reg <= done_armed_next;
      write_collision_flag_flag_reg  <= write_collision_flag_flag_next;
      write_collision_flag_armed_reg <= write_collision_flag_armed_next;
      mode_fault_flag_flag_reg  <= mode_fault_flag_flag_next;
      mode_fault_flag_armed_reg <= mode_fault_flag_armed_next;
      event_reg      <= event_next;
      mask_reg       <= mask_next;
      irq_reg        <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ---------------------------------------------------------------------------
  // Serial pins
  // ---------------------------------------------------------------------------
  // In wired-or mode a pin is only pulled low; a high level is left to a pull-up.
  wire drive_master = enable & master;
  wire drive_slave  = enable & ~master & select_active;
  wire sck_value    = sck_level ^ control_reg[ssdb_pkg::CT_CPOL];

  assign sck_out  = sck_value;
  assign sck_oe   = drive_master & ~(wired_or & sck_value);
  assign mosi_out = out_bit;
  assign mosi_oe  = drive_master & ~(wired_or & out_bit);
  assign miso_out = out_bit;
  assign miso_oe  = drive_slave & ~(wired_or & out_bit);

endmodule : ssdb_top

// ==== ssdb_sva.sv ====
// Port assertions of the serial status and data block.
// Assumes one clock domain; attached from the testbench top file by bind.
`timescale 1ns/10ps
module ssdb_sva (
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic [ssdb_pkg::ADDR_W-1:0] avs_address,
  input wire logic                        avs_read,
  input wire logic                        avs_write,
  input wire logic [31:0]                 avs_readdata,
  input wire logic                        avs_waitrequest,
  input wire logic                        sck_oe,
  input wire logic                        mosi_oe,
  input wire logic                        miso_oe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire logic rd_ans = avs_read && !avs_waitrequest;
  wire logic mapped = avs_address inside {8'hA0, 8'hA4, 8'hA8, 8'hE0, 8'hF0, 8'hF4};
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_answer: assert property (s_req |=> s_answer)
    else $error("bus request not answered for exactly one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("wait released without a request");
  a_readdata_stands: assert property ($changed(avs_readdata) |-> rd_ans)
    else $error("read data moved outside a read answer");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_status_layout: assert property (rd_ans && avs_address == 8'hA4 |->
    avs_readdata[5] == 1'b0 && avs_readdata[3:0] == 4'h0)
    else $error("unused status bits read as one");
  a_options_low: assert property (rd_ans && avs_address == 8'hE0 |->
    avs_readdata[1:0] == 2'b00)
    else $error("unused option bits read as one");
  a_unmapped_zero: assert property (rd_ans && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_oe_exclusive: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave and master drivers both enabled");
endmodule : ssdb_sva

// ==== ssdb_peer.sv ====
// Behavioural serial peer for master transfers with phase one and idle low clock.
// Assumes the block drives on the rising serial edge and samples on the falling one.
`timescale 1ns/10ps
module ssdb_peer (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       bit_order_select,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [2:0] cnt = 3'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] acc = 8'h00;
  initial miso = 1'b1;
  initial rx_byte = 8'h00;
  always @(posedge sck) begin
    if (cnt == 3'h0) sh = tx_byte;
    miso <= sh[bit_order_select ? cnt : ~cnt];
  end
  // Between frames the line shows the inverse of the last bit; before the first frame it is high.
  always @(negedge sck) begin
    acc = bit_order_select ? {mosi, acc[7:1]} : {acc[6:0], mosi};
    if (cnt == 3'h7) begin
      rx_byte <= acc;
      miso <= ~miso;
    end
    cnt = cnt + 3'h1;
  end
endmodule : ssdb_peer

// ==== ssdb_top_tb.sv ====
// Self-checking bench of the serial status and data block.
// Assumes the checker and peer files are compiled before this one.
`timescale 1ns/10ps
module ssdb_top_tb;
  typedef struct {
    logic [2:0] rate;
    logic       bit_order_select;
    logic [7:0] tx;
    logic [7:0] pbyte;
    int         ratio;
  } ssdb_row_t;
  ssdb_row_t rows [5] = '{'{3'h2, 1'b0, 8'hA5, 8'h3C, 16}, '{3'h3, 1'b1, 8'h12, 8'h4E, 32},
    '{3'h4, 1'b0, 8'h01, 8'hC3, 8}, '{3'h6, 1'b1, 8'hF0, 8'h5A, 64},
    '{3'h7, 1'b0, 8'h96, 8'h0F, 128}};
  logic        clock, resetn, avs_read, avs_write, avs_waitrequest, irq, sck_out, sck_oe;
  logic        mosi_out, mosi_oe, miso_in, miso_out, miso_oe, select_n_in, plsbf;
  logic [7:0]  avs_address, ptx, peer_rx, q;
  logic [31:0] avs_writedata, avs_readdata;
  int          num_errors = 0, n_tests = 0, edges = 0, n0;
  time         tp = 0, per = 0;
  ssdb_top dut (.clock, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .irq, .sck_in(1'b0), .sck_out,
    .sck_oe, .mosi_in(1'b0), .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe, .select_n_in);
  ssdb_peer peer (.sck(sck_out), .mosi(mosi_out), .bit_order_select(plsbf), .tx_byte(ptx),
    .miso(miso_in), .rx_byte(peer_rx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) num_errors++;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
    end
  endtask : wait_irq
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  always @(posedge sck_out) begin
    per = $time - tp;
    tp = $time;
    edges++;
  end
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    conclude();
  end
  initial begin
    {resetn, avs_read, avs_write, plsbf} = 4'h0;
    select_n_in = 1'b1;
    {avs_address, ptx} = 16'h0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, 8'hE0, {4'h0, rows[i].bit_order_select, rows[i].rate[2], 2'b00});
      bus(1'b1, 8'hA0, {6'h35, rows[i].rate[1:0]});
      plsbf = rows[i].bit_order_select;
      ptx = rows[i].pbyte;
      bus(1'b1, 8'hA8, rows[i].tx);
      wait_irq();
      chk(irq, 1'b1);
      rd(8'hA4, 8'h80);
      chk({sck_oe, mosi_oe, miso_oe}, 32'h6);
      rd(8'hA8, rows[i].pbyte);
      chk(peer_rx, rows[i].tx);
      chk(32'(per), 32'(rows[i].ratio * 25));
      rd(8'hA4, 8'h00);
    end
    // A write while done is set and unread is lost; a write while busy collides.
    bus(1'b1, 8'hE0, 8'h00);
    bus(1'b1, 8'hA0, 8'hD6);
    plsbf = 1'b0;
    ptx = 8'h66;
    bus(1'b1, 8'hA8, 8'h11);
    wait_irq();
    n0 = edges;
    bus(1'b1, 8'hA8, 8'h22);
    repeat (40) @(posedge clock);
    chk(edges, n0);
    rd(8'hA4, 8'h80);
    bus(1'b1, 8'hA8, 8'h33);
    bus(1'b1, 8'hA8, 8'h44);
    rd(8'hA4, 8'h40);
    wait_irq();
    rd(8'hA4, 8'hC0);
    rd(8'hA8, 8'h66);
    chk(peer_rx, 8'h33);
    rd(8'hA4, 8'h00);
    select_n_in <= 1'b0;
    repeat (8) @(posedge clock);
    select_n_in <= 1'b1;
    rd(8'hA4, 8'h10);
    chk(irq, 1'b1);
    rd(8'hA0, 8'h86);
    bus(1'b1, 8'hA0, 8'h02);
    rd(8'hA4, 8'h00);
    rd(8'hF0, 8'h07);
    bus(1'b1, 8'hF4, 8'h04);
    rd(8'hF4, 8'h04);
    chk(irq, 1'b1);
    bus(1'b1, 8'hF4, 8'h00);
    bus(1'b1, 8'hF0, 8'h07);
    bus(1'b1, 8'hF4, 8'h07);
    rd(8'hF0, 8'h00);
    chk(irq, 1'b0);
    bus(1'b1, 8'hA0, 8'h42);
    n0 = edges;
    select_n_in <= 1'b0;
    bus(1'b1, 8'hA8, 8'h55);
    repeat (40) @(posedge clock);
    select_n_in <= 1'b1;
    chk(edges, n0);
    rd(8'hA4, 8'h00);
    bus(1'b1, 8'hE0, 8'hFF);
    rd(8'hE0, 8'hFC);
    bus(1'b1, 8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(8'hA4, 8'h00);
    rd(8'hA0, 8'h04);
    rd(8'hE0, 8'h00);
    chk({sck_oe, mosi_oe, miso_oe}, 32'h0);
    chk(irq, 1'b0);
    conclude();
  end
endmodule : ssdb_top_tb
bind ssdb_top ssdb_sva sva (.clock, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .sck_oe, .mosi_oe, .miso_oe);
